// *** src/sgcl_pkg.sv ***
// Package of constants and types for the serial gain code loader.
package sgcl_pkg;

    // ****************************************
    // Widths and layout
    // ****************************************
    localparam int SHIFT_W    = 7;            // Width of the shift register.
    localparam int WORD_BITS  = 8;            // Bits in one gain word.
    localparam int FINE_W     = 3;            // Width of the fine step index.
    localparam int COARSE_W   = 4;            // Width of the coarse step index.
    localparam int FINE_LSB   = 0;            // Position of the fine field.
    localparam int COARSE_LSB = 3;            // Position of the coarse field.

    // ****************************************
    // Gain law constants
    // ****************************************
    localparam logic [6:0] CODE_MAX_GAIN = 7'h47;   // Code 71, highest gain.
    localparam logic [6:0] CODE_RESET    = 7'h00;   // Code held after reset.
    localparam logic [2:0] FINE_SPAN     = 3'h7;    // Highest fine step; a coarse step spans 8 fine steps.
    localparam logic [7:0] BITCNT_RESET  = 8'h00;   // Bit counter reset value.

    // ****************************************
    // Types
    // ****************************************
    // Sequencer states, Gray coded along idle, shifting, apply.
    typedef enum logic [1:0] {
        SGCL_IDLE  = 2'b00,
        SGCL_SHIFT = 2'b01,
        SGCL_APPLY = 2'b11
    } sgcl_state_t;

    // Decoded attenuator setting handed to the analog core.
    typedef struct packed {
        logic [6:0] code;      // Latched gain code.
        logic [6:0] atten;     // Attenuation steps below maximum gain.
        logic [2:0] fine;      // Fine stage step.
        logic [3:0] coarse;    // Coarse stage step.
    } sgcl_gain_t;

    // Power state outputs.
    typedef struct packed {
        logic sleep;           // Low-power state, output in high impedance.
        logic transmit;        // Powered up and transmitting.
        logic out_oe;          // Output stage driving.
    } sgcl_power_t;

endpackage

// *** src/sgcl_sync.sv ***
// Two-flop synchroniser bank for the serial link and power control pins.
`timescale 1ns/10ps
module sgcl_sync #(
    parameter int W = 5
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous inputs and synchronised outputs.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;    // First stage, read only by the second.
    logic [W-1:0] meta_next;   // Next value of the first stage.
    logic [W-1:0] sync_reg;    // Second stage.
    logic [W-1:0] sync_next;   // Next value of the second stage.

    // ****************************************
    // Next values
    // ****************************************
    // Reset parks both stages low.
    always_comb begin
        meta_next = rst_n ? async_in : '0;
        sync_next = rst_n ? meta_reg : '0;
    end

    // Registers only.
    always_ff @(posedge clk) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg;

endmodule

// *** src/sgcl_loader.sv ***
// Serial gain code loader: three-wire link, shift register, latch and gain decode.
// Rules for this block and its host
// (R1) Sleep low gives low power, output high-Z.
// (R2) Load enable falling edge opens serial clocking.
// (R3) Applied gain held while shifting.
// (R4) Sample data on serial clock rising edge.
// (R5) Seven-bit register drops the first bit.
// (R6) Host sends exactly eight bits per change.
// (R7) Load enable rising edge applies shift register.
// (R8) Codes 0 to 71 follow linear gain law.
// (R9) Codes 72 to 127 repeat fine span.
// (R10) Top bit ignored, codes alias modulo 128.
// (R11) Serial clocks ignored while load enable high.
// (R12) Power-down low disables transmit, high transmits.
// (R13) Hold power-down low until gain programmed.
// (R14) Latched code changes only on load rising edge.
`timescale 1ns/10ps
module sgcl_loader (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Serial link pins.
    input  wire logic                 load_enable_n,
    input  wire logic                 serial_gain_in,
    input  wire logic                 serial_clk,
    // Power control pins.
    input  wire logic                 power_down_n,
    input  wire logic                 sleep_n,
    // Attenuator and power outputs.
    output sgcl_pkg::sgcl_gain_t      gain,
    output sgcl_pkg::sgcl_power_t     power,
    output logic [7:0]                bits_seen
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [4:0]             pins_sync;       // Synchronised pins.
    logic                   en_n_s;          // Synchronised load enable.
    logic                   sdat_s;          // Synchronised serial data.
    logic                   sclk_s;          // Synchronised serial clock.
    logic                   pd_n_s;          // Synchronised power-down.
    logic                   slp_n_s;         // Synchronised sleep.
    logic                   sclk_d_reg;      // Previous serial clock level.
    logic                   sclk_d_next;     // Next previous serial clock.
    logic                   en_d_reg;        // Previous load enable level.
    logic                   en_d_next;       // Next previous load enable.
    logic                   sclk_rise;       // Serial clock rising edge.
    logic                   en_fall;         // Load enable falling edge.
    logic                   en_rise;         // Load enable rising edge.
    sgcl_pkg::sgcl_state_t  state_reg;       // Sequencer state.
    sgcl_pkg::sgcl_state_t  state_next;      // Next sequencer state.
    logic [6:0]             shift_reg;       // Serial shift register.
    logic [6:0]             shift_next;      // Next shift register.
    logic [6:0]             code_reg;        // Latched gain code.
    logic [6:0]             code_next;       // Next latched code.
    logic [7:0]             cnt_reg;         // Bits shifted in this load.
    logic [7:0]             cnt_next;        // Next bit count.
    sgcl_pkg::sgcl_gain_t   gain_reg;        // Registered decoded gain.
    sgcl_pkg::sgcl_gain_t   gain_next;       // Next decoded gain.
    logic [6:0]             atten_w;         // Attenuation of the latched code.
    sgcl_pkg::sgcl_power_t  power_reg;       // Registered power state.
    sgcl_pkg::sgcl_power_t  power_next;      // Next power state.

    // Attenuation steps below maximum gain for a 7-bit code.
    function automatic logic [6:0] atten_of(input logic [6:0] c);
        logic [6:0] a;
        a = 7'h00;
        if (c <= sgcl_pkg::CODE_MAX_GAIN) begin
            a = sgcl_pkg::CODE_MAX_GAIN - c;                       // R8
        end else begin
            a = {4'h0, sgcl_pkg::FINE_SPAN - c[2:0]};              // R9
        end
        return a;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    sgcl_sync #(
        .W (5)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({sleep_n, power_down_n, serial_clk, serial_gain_in, load_enable_n}),
        .sync_out (pins_sync)
    );

    assign en_n_s  = pins_sync[0];
    assign sdat_s  = pins_sync[1];
    assign sclk_s  = pins_sync[2];
    assign pd_n_s  = pins_sync[3];
    assign slp_n_s = pins_sync[4];

    // ****************************************
    // Edge detection
    // ****************************************
    // Previous levels reset to the synchroniser's reset level; a high load enable still gives one rise after reset, ignored in idle.
    always_comb begin
        sclk_d_next = rst_n ? sclk_s : 1'b0;
        en_d_next   = rst_n ? en_n_s : 1'b0;
    end

    always_ff @(posedge clk) begin
        sclk_d_reg <= sclk_d_next;
        en_d_reg   <= en_d_next;
    end

    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign en_fall   = ~en_n_s & en_d_reg;
    assign en_rise   = en_n_s & ~en_d_reg;

    // ****************************************
    // Load sequencer, shift register and latch
    // ****************************************
    // Shifting is only armed by a falling load enable; the latch moves only on its rise.
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        code_next  = code_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            sgcl_pkg::SGCL_IDLE: begin
                // Clock edges here are ignored.                         R11
                if (en_fall) begin
                    state_next = sgcl_pkg::SGCL_SHIFT;                 // R2
                    cnt_next   = sgcl_pkg::BITCNT_RESET;
                end
            end
            sgcl_pkg::SGCL_SHIFT: begin
                if (en_rise) begin
                    state_next = sgcl_pkg::SGCL_APPLY;
                end else if (sclk_rise) begin
                    // Oldest bit falls off the top, so bit 8 of 8 drops the MSB.
                    shift_next = {shift_reg[5:0], sdat_s};             // R4 R5
                    cnt_next   = cnt_reg + 8'h01;
                end
                // Latched code untouched while shifting.                R3
            end
            sgcl_pkg::SGCL_APPLY: begin
                code_next  = shift_reg;                                // R7 R14
                state_next = sgcl_pkg::SGCL_IDLE;
            end
            default: begin
                state_next = sgcl_pkg::SGCL_IDLE;
            end
        endcase
        if (!rst_n) begin
            state_next = sgcl_pkg::SGCL_IDLE;
            shift_next = sgcl_pkg::CODE_RESET;
            code_next  = sgcl_pkg::CODE_RESET;
            cnt_next   = sgcl_pkg::BITCNT_RESET;
        end
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
        shift_reg <= shift_next;
        code_reg  <= code_next;
        cnt_reg   <= cnt_next;
    end

    // ****************************************
    // Gain decode and power state
    // ****************************************
    // A 7-bit latch means codes 128 to 255 already alias 0 to 127.    R10
    // The latched code is decoded once and split into fine and coarse steps.
    always_comb begin
        atten_w             = atten_of(code_reg);                      // R8 R9
        gain_next.code      = code_reg;
        gain_next.atten     = atten_w;
        gain_next.fine      = atten_w[sgcl_pkg::FINE_LSB +: sgcl_pkg::FINE_W];
        gain_next.coarse    = atten_w[sgcl_pkg::COARSE_LSB +: sgcl_pkg::COARSE_W];
        power_next.sleep    = rst_n & ~slp_n_s;                        // R1
        power_next.out_oe   = rst_n & slp_n_s;                         // R1
        power_next.transmit = rst_n & slp_n_s & pd_n_s;               // R12 R13
    end

    // Registers only.
    always_ff @(posedge clk) begin
        gain_reg  <= gain_next;
        power_reg <= power_next;
    end

    assign gain      = gain_reg;
    assign power     = power_reg;
    assign bits_seen = cnt_reg;

    // ****************************************
    // Assertions
    // ****************************************
    sequence load_open_s;
        state_reg == sgcl_pkg::SGCL_IDLE && en_fall;
    endsequence

    latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)  // R3
        (state_reg != sgcl_pkg::SGCL_APPLY) |=> code_reg == $past(code_reg))
        else $error("Latched code changed outside apply.");

    apply_copy_a: assert property (@(posedge clk) disable iff (!rst_n)  // R7
        (state_reg == sgcl_pkg::SGCL_SHIFT && en_rise) |=> ##1 code_reg == $past(shift_reg, 2))
        else $error("Apply did not copy shift register.");

    open_shift_a: assert property (@(posedge clk) disable iff (!rst_n)  // R2
        load_open_s |=> state_reg == sgcl_pkg::SGCL_SHIFT && cnt_reg == 8'h00)
        else $error("Falling enable did not open shifting.");

    shift_in_a: assert property (@(posedge clk) disable iff (!rst_n)  // R4
        (state_reg == sgcl_pkg::SGCL_SHIFT && !en_rise && sclk_rise)
        |=> shift_reg == {$past(shift_reg[5:0]), $past(sdat_s)})
        else $error("Serial bit not shifted in.");

    idle_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)  // R11
        (state_reg == sgcl_pkg::SGCL_IDLE) |=> shift_reg == $past(shift_reg))
        else $error("Shift register moved while idle.");

    gain_law_a: assert property (@(posedge clk) disable iff (!rst_n)  // R8
        (code_reg <= sgcl_pkg::CODE_MAX_GAIN && $stable(code_reg))
        |=> gain_reg.atten == sgcl_pkg::CODE_MAX_GAIN - $past(code_reg))
        else $error("Linear gain law broken.");

    saw_law_a: assert property (@(posedge clk) disable iff (!rst_n)  // R9
        (code_reg > sgcl_pkg::CODE_MAX_GAIN)
        |=> gain_reg.atten == {4'h0, sgcl_pkg::FINE_SPAN - $past(code_reg[2:0])})
        else $error("Sawtooth gain law broken.");

    sleep_out_a: assert property (@(posedge clk) disable iff (!rst_n)  // R1
        !slp_n_s |=> power_reg.sleep && !power_reg.out_oe && !power_reg.transmit)
        else $error("Sleep did not quiet the output.");

    pd_tx_a: assert property (@(posedge clk) disable iff (!rst_n)  // R12
        (slp_n_s && pd_n_s) |=> power_reg.transmit)
        else $error("Powered up but not transmitting.");

endmodule

// *** verif/sgcl_host_model.sv ***
// Host controller model that drives the three-wire serial gain link.
`timescale 1ns/10ps
module sgcl_host_model (
    // Bench clock that times the link.
    input  wire logic clk,
    // Link pins toward the loader.
    output logic      load_enable_n,
    output logic      serial_gain_in,
    output logic      serial_clk
);
    localparam int HALF = 4;  // Clock cycles in half of the 800 ns link period.

    // The link idles with enable high and the serial clock standing low.
    initial begin
        load_enable_n  = 1'b1;
        serial_gain_in = 1'b0;
        serial_clk     = 1'b0;
    end

    // Waits half a link period and steps just past the clock edge.
    task automatic wait_half();
        repeat (HALF) @(posedge clk);
        #1;
    endtask

    // Opens a load with a falling enable before any data bit.
    task automatic start_frame();
        wait_half();
        load_enable_n = 1'b0;
    endtask

    // Sends one bit; data moves with the falling clock, so one bit takes one link period.
    task automatic send_bit(input logic b);
        serial_gain_in = b;
        wait_half();
        serial_clk = 1'b1;
        wait_half();
        serial_clk = 1'b0;
    endtask

    // Closes a load with a rising enable, then leaves a gap.
    task automatic end_frame();
        wait_half();
        load_enable_n  = 1'b1;
        // The line no longer shows the last bit once the load is closed.
        serial_gain_in = ~serial_gain_in;
        wait_half();
    endtask

    // Pulses the clock with enable high, a fault the loader must ignore.
    task automatic idle_clocks(input logic [7:0] pat);
        for (int i = 0; i < 8; i++) begin
            serial_gain_in = pat[i];
            wait_half();
            serial_clk = 1'b1;
            wait_half();
            serial_clk = 1'b0;
        end
    endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the serial gain code loader.
`timescale 1ns/10ps
module tb_top;
    // ****************************************
    // Signals
    // ****************************************
    logic                  clk;            // System clock, 100 ns period.
    logic                  rst_n;          // Synchronous reset, active low.
    logic                  load_enable_n;  // Link enable from the host.
    logic                  serial_gain_in; // Link data from the host.
    logic                  serial_clk;     // Link clock from the host.
    logic                  power_down_n;   // Power-down pin, active low.
    logic                  sleep_n;        // Sleep pin, active low.
    sgcl_pkg::sgcl_gain_t  gain;           // Decoded gain.
    sgcl_pkg::sgcl_power_t power;          // Power state.
    logic [7:0]            bits_seen;      // Clock rises in the current load.
    int                    err_total;      // Mismatches found.
    int                    n_compared;     // Comparisons made.
    logic [31:0]           rng;            // Xorshift state.
    logic [6:0]            sreg;           // Expected shift register.
    logic [7:0]            word;           // Word being sent.
    logic [7:0]            corner [8] = '{8'h00, 8'h47, 8'h48, 8'h7F, 8'h80, 8'hFF, 8'hC7, 8'h01};

    // The clock inverts every half period.
    initial clk = 1'b0;
    always #50 clk = ~clk;

    sgcl_loader u_sgcl_loader (.clk(clk), .rst_n(rst_n), .load_enable_n(load_enable_n),
        .serial_gain_in(serial_gain_in), .serial_clk(serial_clk), .power_down_n(power_down_n),
        .sleep_n(sleep_n), .gain(gain), .power(power), .bits_seen(bits_seen));
    sgcl_host_model u_sgcl_host_model (.clk(clk), .load_enable_n(load_enable_n),
        .serial_gain_in(serial_gain_in), .serial_clk(serial_clk));

    // ****************************************
    // Helpers
    // ****************************************
    // Expected decode; above code 71 only the fine stage sweeps.
    function automatic sgcl_pkg::sgcl_gain_t exp_gain(input logic [6:0] c);
        sgcl_pkg::sgcl_gain_t g;
        g.code   = c;
        g.atten  = (c <= sgcl_pkg::CODE_MAX_GAIN) ? sgcl_pkg::CODE_MAX_GAIN - c
                                                  : {4'h0, sgcl_pkg::FINE_SPAN - c[2:0]};
        g.fine   = g.atten[2:0];
        g.coarse = g.atten[6:3];
        return g;
    endfunction

    // Next xorshift value.
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Shifts bits hi down to lo, tracking the register.
    task automatic shift_bits(input logic [7:0] w, input int hi, input int lo);
        for (int i = hi; i >= lo; i--) begin
            u_sgcl_host_model.send_bit(w[i]);
            sreg = {sreg[5:0], w[i]};
        end
    endtask

    // Ends a load and waits past the apply latency.
    task automatic finish_frame();
        u_sgcl_host_model.end_frame();
        repeat (4) @(posedge clk);
        #1;
        check({11'h0, gain}, {11'h0, exp_gain(sreg)});
    endtask

    // Prints the counts and the verdict.
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        err_total = 0;
        n_compared = 0;
        rng = 32'h0000D3F8;
        sreg = 7'h00;
        rst_n = 1'b0;
        power_down_n = 1'b0;
        sleep_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({11'h0, gain}, {11'h0, exp_gain(7'h00)});
        check({29'h0, power}, {29'h0, 3'b001});
        // Corner codes first, then random words.
        for (int i = 0; i < 32; i++) begin
            rng = next_rand(rng);
            word = (i < 8) ? corner[i] : rng[7:0];
            u_sgcl_host_model.start_frame();
            shift_bits(word, 7, 0);
            finish_frame();
            check({24'h0, bits_seen}, 32'h8);
            check({25'h0, gain.code}, {25'h0, word[6:0]});
        end
        // Gain stays put while a load is half done.
        rng = next_rand(rng);
        u_sgcl_host_model.start_frame();
        shift_bits(rng[7:0], 7, 3);
        check({25'h0, gain.code}, {25'h0, word[6:0]});
        shift_bits(rng[7:0], 2, 0);
        finish_frame();
        // Every sleep and power-down combination.
        for (int i = 0; i < 4; i++) begin
            {sleep_n, power_down_n} = i[1:0];
            repeat (5) @(posedge clk);
            #1;
            check({29'h0, power}, {29'h0, ~i[1], i[1] & i[0], i[1]});
        end
        // Clocks with enable high leave the register alone.
        rng = next_rand(rng);
        u_sgcl_host_model.idle_clocks(rng[7:0]);
        u_sgcl_host_model.start_frame();
        finish_frame();
        check({24'h0, bits_seen}, 32'h0);
        // A short load keeps older bits.
        rng = next_rand(rng);
        u_sgcl_host_model.start_frame();
        shift_bits(rng[7:0], 4, 0);
        finish_frame();
        close_out();
    end
endmodule
